// file: rtl/mocount_pkg.sv
// constants, field layouts and carrier types for the match output and count input block
// assumes an apb slave at 40 mhz pclk with active-low asynchronous reset
// How it works
// - match applies action: keep, clear, set, toggle
// - channel 1 action in bits 7:6
// - channel 2 action in bits 9:8
// - channel 3 action in bits 11:10
// - match pin follows its match bit
// - count control picks timer or counter
// - sample chosen capture input every clock
// - compare samples: rising, falling, none
// - increment only on selected edge kind
// - bit reflects state; channel 0 bits 5:4
// - mode 0 timer, 1 rise, 2 fall, 3 both
package mocount_pkg;

  // register byte addresses
  localparam logic [31:0] match_output_control_addr = 32'h4001_403c;
  localparam logic [31:0] count_control_addr = 32'h4001_4070;
  localparam logic [31:0] timer_count_value_addr = 32'h4001_4008;
  localparam logic [31:0] match_value_base_addr = 32'h4001_4018;

  // match output control field positions
  localparam int match_bit_lsb = 0;
  localparam int match_action_lsb = 4;
  localparam int match_action_w = 2;
  localparam int match_used_w = 12;
  localparam int match_channels = 4;

  // count control field positions
  localparam int count_mode_lsb = 0;
  localparam int count_input_lsb = 2;
  localparam int count_used_w = 4;

  // reset values
  localparam logic [11:0] match_output_control_rst = 12'h000;
  localparam logic [3:0] count_control_rst = 4'h0;
  localparam logic [31:0] timer_count_rst = 32'h0000_0000;
  localparam logic [31:0] match_value_rst = 32'h0000_0000;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;

  // match actions
  typedef enum logic [1:0] {
    act_nothing = 2'h0,
    act_clear = 2'h1,
    act_set = 2'h2,
    act_toggle = 2'h3
  } match_action_e;

  // count modes
  typedef enum logic [1:0] {
    mode_timer = 2'h0,
    mode_rise = 2'h1,
    mode_fall = 2'h2,
    mode_both = 2'h3
  } count_mode_e;

  // count control as stored
  typedef struct packed {
    logic [1:0] input_sel;
    count_mode_e mode;
  } count_control_s;

  // edge classification
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_s;

endpackage

// file: rtl/edge_sampler.sv
// edge detector for the counted capture input
// assumes the input is already synchronised to pclk by the caller
`timescale 1ns/100ps
`default_nettype none
module edge_sampler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sample and mode
  input wire logic sample,
  input wire logic counting,
  // classification
  output mocount_pkg::edge_s edges
);
  import mocount_pkg::*;

  logic prev_reg;

  // previous sample; loaded in timer mode too so entering counter mode never counts a stale edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sample;
    end
  end

  // compare two consecutive samples, gated off outside counter mode
  always_comb begin
    edges.rise = counting & sample & ~prev_reg;
    edges.fall = counting & ~sample & prev_reg;
  end

  chk_timer_no_edge: assert property (@(posedge pclk) disable iff (!presetn)
    !counting |-> (edges == 2'b00))
    else $error("edge seen in timer mode");

endmodule
`default_nettype wire

// file: rtl/match_count.sv
// match output logic and counter-mode input path with an apb register file
// assumes apb master on pclk; capture inputs are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module match_count #(
  parameter int cap_inputs = 4
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // capture pins
  input wire logic [cap_inputs-1:0] capture_input,
  // match pins and timer count value
  output logic [3:0] match_output_pin,
  output logic [31:0] timer_count_value
);
  import mocount_pkg::*;

  // elaboration check: the two-bit select field reaches four inputs at most
  if (cap_inputs < 1 || cap_inputs > 4) begin : g_bad_cap_inputs
    $error("cap_inputs must be 1..4");
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [match_used_w-1:0] match_output_control_reg;
  logic [match_used_w-1:0] match_output_control_next;
  count_control_s count_control_reg;
  logic [31:0] timer_count_reg;
  logic [31:0] timer_count_next;
  logic [31:0] match_value_reg [match_channels];
  logic [cap_inputs-1:0] cap_meta_reg;
  logic [cap_inputs-1:0] cap_sync_reg;
  logic sel_sample;
  logic counting;
  logic count_step;
  edge_s edges;
  logic [match_channels-1:0] match_hit;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rd_data;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, unmapped reads zero with an error

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  always_comb begin
    rd_data = unmapped_read;
    mapped = 1'b1;
    if (paddr == match_output_control_addr) begin
      rd_data = {20'h0_0000, match_output_control_reg};
    end else if (paddr == count_control_addr) begin
      rd_data = {28'h000_0000, count_control_reg};
    end else if (paddr == timer_count_value_addr) begin
      rd_data = timer_count_reg;
    end else begin
      mapped = 1'b0;
      for (int i = 0; i < match_channels; i++) begin
        if (paddr == match_value_base_addr + 32'(i * 4)) begin
          rd_data = match_value_reg[i];
          mapped = 1'b1;
        end
      end
    end
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= unmapped_read;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd_acc) begin
        prdata <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count control and match values

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_control_reg <= count_control_s'(count_control_rst);
    end else if (wr_acc && paddr == count_control_addr) begin
      count_control_reg <= count_control_s'(pwdata[count_used_w-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < match_channels; i++) begin
        match_value_reg[i] <= match_value_rst;
      end
    end else begin
      for (int i = 0; i < match_channels; i++) begin
        if (wr_acc && paddr == match_value_base_addr + 32'(i * 4)) begin
          match_value_reg[i] <= pwdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture input: two-flop synchroniser, then selection

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_meta_reg <= '0;
      cap_sync_reg <= '0;
    end else begin
      cap_meta_reg <= capture_input;
      cap_sync_reg <= cap_meta_reg;
    end
  end

  // reserved selections read input 0 rather than a floating value
  always_comb begin
    sel_sample = cap_sync_reg[0];
    if (int'(count_control_reg.input_sel) < cap_inputs) begin
      sel_sample = cap_sync_reg[count_control_reg.input_sel];
    end
  end

  assign counting = (count_control_reg.mode != mode_timer);

  edge_sampler u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sample(sel_sample),
    .counting(counting),
    .edges(edges)
  );

  ////////////////////////////////////////////////////////////////////////
  // timer counter: every clock in timer mode, selected edges otherwise

  always_comb begin
    case (count_control_reg.mode)
      mode_timer: count_step = 1'b1;
      mode_rise: count_step = edges.rise;
      mode_fall: count_step = edges.fall;
      mode_both: count_step = edges.rise | edges.fall;
      default: count_step = 1'b0;
    endcase
  end

  always_comb begin
    timer_count_next = timer_count_reg;
    if (wr_acc && paddr == timer_count_value_addr) begin
      timer_count_next = pwdata;
    end else if (count_step) begin
      timer_count_next = timer_count_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_reg <= timer_count_rst;
      timer_count_value <= timer_count_rst;
    end else begin
      timer_count_reg <= timer_count_next;
      timer_count_value <= timer_count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // match events and output bits; a clear, set or toggle match beats a same-cycle software write of the bit

  always_comb begin
    for (int i = 0; i < match_channels; i++) begin
      match_hit[i] = (timer_count_reg == match_value_reg[i]);
    end
  end

  always_comb begin
    match_action_e act;
    act = act_nothing;
    match_output_control_next = match_output_control_reg;
    if (wr_acc && paddr == match_output_control_addr) begin
      match_output_control_next = pwdata[match_used_w-1:0];
    end
    for (int i = 0; i < match_channels; i++) begin
      act = match_action_e'(match_output_control_reg[match_action_lsb + i*match_action_w +: match_action_w]);
      if (match_hit[i]) begin
        case (act)
          act_nothing: match_output_control_next[i] = match_output_control_next[i];
          act_clear: match_output_control_next[i] = 1'b0;
          act_set: match_output_control_next[i] = 1'b1;
          act_toggle: match_output_control_next[i] = ~match_output_control_reg[i];
          default: match_output_control_next[i] = match_output_control_reg[i];
        endcase
      end
    end
  end

  // pin copy registered alongside the bit so both change on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_output_control_reg <= match_output_control_rst;
      match_output_pin <= 4'h0;
    end else begin
      match_output_control_reg <= match_output_control_next;
      match_output_pin <= match_output_control_next[match_channels-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_hit_toggle(int i);
    match_hit[i] && match_output_control_reg[match_action_lsb+2*i +: 2] == 2'b11 && !wr_acc;
  endsequence

  // two consecutive samples of the counted input, the second taken while counting
  sequence s_low_then_high;
    !sel_sample ##1 (sel_sample && counting);
  endsequence

  sequence s_high_then_low;
    sel_sample ##1 (!sel_sample && counting);
  endsequence

  // match actions and the register write path
  chk_toggle_ch0: assert property (@(posedge pclk) disable iff (!presetn)
    s_hit_toggle(0) |=> match_output_control_reg[0] != $past(match_output_control_reg[0]))
    else $error("toggle did not invert bit 0");
  chk_set_ch0: assert property (@(posedge pclk) disable iff (!presetn)
    match_hit[0] && match_output_control_reg[5:4] == 2'b10 |=> match_output_control_reg[0])
    else $error("set did not raise bit 0");
  chk_clear_ch0: assert property (@(posedge pclk) disable iff (!presetn)
    match_hit[0] && match_output_control_reg[5:4] == 2'b01 |=> !match_output_control_reg[0])
    else $error("clear did not lower bit 0");
  chk_clear_ch1: assert property (@(posedge pclk) disable iff (!presetn)
    match_hit[1] && match_output_control_reg[7:6] == 2'b01 |=> !match_output_control_reg[1])
    else $error("clear did not lower bit 1");
  chk_set_ch2: assert property (@(posedge pclk) disable iff (!presetn)
    match_hit[2] && match_output_control_reg[9:8] == 2'b10 |=> match_output_control_reg[2])
    else $error("set did not raise bit 2");
  chk_keep_ch3: assert property (@(posedge pclk) disable iff (!presetn)
    match_hit[3] && match_output_control_reg[11:10] == 2'b00 && !wr_acc |=> $stable(match_output_control_reg[3]))
    else $error("do nothing changed bit 3");
  chk_toggle_ch3: assert property (@(posedge pclk) disable iff (!presetn)
    s_hit_toggle(3) |=> match_output_control_reg[3] != $past(match_output_control_reg[3]))
    else $error("toggle did not invert bit 3");
  chk_ctl_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == match_output_control_addr && match_hit == '0
    |=> match_output_control_reg == $past(pwdata[match_used_w-1:0]))
    else $error("match control write not stored");
  chk_pin_follows: assert property (@(posedge pclk) disable iff (!presetn)
    match_output_pin == match_output_control_reg[3:0])
    else $error("match pin differs from bit");

  // counted input path and timer counter
  chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cap_sync_reg[0]) |-> $past(capture_input[0], 2))
    else $error("capture sample not two flops late");
  chk_rise_classed: assert property (@(posedge pclk) disable iff (!presetn)
    s_low_then_high |-> edges.rise)
    else $error("rising input edge not classified");
  chk_fall_classed: assert property (@(posedge pclk) disable iff (!presetn)
    s_high_then_low |-> edges.fall)
    else $error("falling input edge not classified");
  chk_steady_no_edge: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(sel_sample) |-> edges == 2'b00)
    else $error("edge seen on a steady input");
  chk_timer_steps: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_timer && !wr_acc |=> timer_count_reg == $past(timer_count_reg) + 32'h0000_0001)
    else $error("timer mode did not step");
  chk_rise_count: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_rise && !wr_acc && !edges.rise |=> $stable(timer_count_reg))
    else $error("counted without rising edge");
  chk_rise_step: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_rise && !wr_acc && edges.rise
    |=> timer_count_reg == $past(timer_count_reg) + 32'h0000_0001)
    else $error("rising edge not counted");
  chk_fall_count: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_fall && !wr_acc && edges.fall
    |=> timer_count_reg == $past(timer_count_reg) + 32'h0000_0001)
    else $error("falling edge not counted");
  chk_fall_hold: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_fall && !wr_acc && !edges.fall |=> $stable(timer_count_reg))
    else $error("counted without falling edge");
  chk_both_step: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_both && !wr_acc && (edges.rise || edges.fall)
    |=> timer_count_reg == $past(timer_count_reg) + 32'h0000_0001)
    else $error("edge not counted in both-edge mode");
  chk_both_hold: assert property (@(posedge pclk) disable iff (!presetn)
    count_control_reg.mode == mode_both && !wr_acc && !edges.rise && !edges.fall |=> $stable(timer_count_reg))
    else $error("counted without any edge");

  // register bus answer: one access cycle after every setup
  chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no answer after setup cycle");
  chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood past one cycle");

endmodule
`default_nettype wire

// file: sim/pulse_src.sv
// external pulse source model for the capture pins
// assumes the block samples the pins asynchronously; pins idle low
`timescale 1ns/100ps
`default_nettype none
module pulse_src (
  // capture pins
  output logic [3:0] cap_pins
);
  ////////////////////////////////////////////////////////////////
  // idle level at time zero
  initial begin
    cap_pins = 4'h0;
  end
  // n pulses; each level stands at least one pclk period, never faster than half the clock
  task automatic burst(input int ch, input int n, input int half_ns);
    #3;
    for (int i = 0; i < n; i++) begin
      #(half_ns) cap_pins[ch] = 1'h1;
      #(half_ns) cap_pins[ch] = 1'h0;
    end
  endtask
  // static level, moved off the clock edge to avoid a sampling race
  task automatic hold_level(input int ch, input logic lvl);
    #3 cap_pins[ch] = lvl;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the match output and count input block
// assumes the design package is compiled first and the pulse model sits on the capture pins
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mocount_pkg::*;
  ////////////////////////////////////////////////////////////////
  // bench signals, all driven from time zero
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] cap_pins;
  logic [3:0] match_output_pin;
  logic [31:0] timer_count_value;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] tc_a;
  logic [31:0] tc_b;
  // kind 0: match action on a channel; kind 1: edge count on a pin
  typedef struct {
    int kind;
    int ch;
    logic [1:0] code;
    int arg;
    int n;
    logic [31:0] exp;
  } row_s;
  row_s rows[26];
  // keep, clear, set, toggle from 0, toggle from 1
  logic [1:0] acts[5] = '{act_nothing, act_clear, act_set, act_toggle, act_toggle};
  int inits[5] = '{1, 1, 0, 0, 1};
  logic exps[5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
  ////////////////////////////////////////////////////////////////
  // clock, block and far-side model
  always #12.5 pclk = ~pclk;
  match_count #(.cap_inputs(4)) u_match_count (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input(cap_pins),
    .match_output_pin(match_output_pin), .timer_count_value(timer_count_value));
  pulse_src u_pulse_src (.cap_pins(cap_pins));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits on pready, the watchdog cuts a hang
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [31:0] addr, input logic [31:0] wdata);
    apb(1'h1, addr, wdata);
  endtask
  task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
    apb(1'h0, addr, 32'h0000_0000);
    check(rd, exp);
    check({31'h0000_0000, err}, 32'h0000_0000);
  endtask
  // timer passes the match value once, far from the start value
  task automatic run_match(input row_s r);
    logic [31:0] ctl;
    logic [31:0] e;
    ctl = (32'(r.code) << (4 + 2 * r.ch)) | (32'(r.arg) << r.ch);
    e = (32'(r.code) << (4 + 2 * r.ch)) | (r.exp << r.ch);
    wr(match_value_base_addr + 32'(4 * r.ch), 32'h0000_003c);
    wr(timer_count_value_addr, 32'h0000_03e8);
    wr(match_output_control_addr, ctl);
    wr(timer_count_value_addr, 32'h0000_0000);
    repeat (80) @(posedge pclk);
    #1;
    check({28'h000_0000, match_output_pin}, e & 32'h0000_000f);
    rdchk(match_output_control_addr, e);
  endtask
  task automatic run_count(input row_s r, input int i);
    wr(count_control_addr, {28'h000_0000, 2'(r.arg), r.code});
    wr(timer_count_value_addr, 32'h0000_0000);
    u_pulse_src.burst(r.ch, r.n, (i % 2) ? 26 : 125);
    repeat (6) @(posedge pclk);
    rdchk(count_control_addr, {28'h000_0000, 2'(r.arg), r.code});
    rdchk(timer_count_value_addr, r.exp);
    check(timer_count_value, r.exp);
  endtask
  // input moves only while in timer operation; the count must not see it
  task automatic edge_hold(input logic lvl, output logic [31:0] tc);
    wr(count_control_addr, 32'h0000_0001);
    wr(count_control_addr, 32'h0000_0000);
    u_pulse_src.hold_level(0, lvl);
    repeat (5) @(posedge pclk);
    wr(timer_count_value_addr, 32'h0000_01f4);
    wr(count_control_addr, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    apb(1'h0, timer_count_value_addr, 32'h0000_0000);
    tc = rd;
    u_pulse_src.hold_level(0, 1'h0);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    final_report();
  end
  // main sequence: table rows first, then the hand-written cases
  initial begin
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 5; a++) begin
        rows[c * 5 + a] = '{0, c, acts[a], inits[a], 0, {31'h0000_0000, exps[a]}};
      end
    end
    rows[20] = '{1, 0, 2'h1, 0, 3, 32'h0000_0003};
    rows[21] = '{1, 0, 2'h2, 0, 3, 32'h0000_0003};
    rows[22] = '{1, 0, 2'h3, 0, 3, 32'h0000_0006};
    rows[23] = '{1, 2, 2'h1, 2, 4, 32'h0000_0004};
    rows[24] = '{1, 1, 2'h3, 0, 4, 32'h0000_0000};
    rows[25] = '{1, 3, 2'h3, 3, 2, 32'h0000_0004};
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].kind == 0) run_match(rows[i]);
      else run_count(rows[i], i);
    end
    // match values read back from their own words, not a neighbour's
    wr(match_value_base_addr + 32'h0000_0008, 32'h0000_0100);
    rdchk(match_value_base_addr, 32'h0000_003c);
    rdchk(match_value_base_addr + 32'h0000_0008, 32'h0000_0100);
    // unmapped place: write ignored, read refused with zero data
    wr(32'h4001_4000, 32'h0000_ffff);
    apb(1'h0, 32'h4001_4000, 32'h0000_0000);
    check(rd, unmapped_read);
    check({31'h0000_0000, err}, 32'h0000_0001);
    edge_hold(1'h0, tc_a);
    edge_hold(1'h1, tc_b);
    check(tc_b, tc_a);
    // second reset in mid-run with outputs set
    wr(match_output_control_addr, 32'h0000_0fff);
    presetn <= 1'h0;
    repeat (8) @(posedge pclk);
    #1;
    check({28'h000_0000, match_output_pin}, 32'h0000_0000);
    presetn <= 1'h1;
    rdchk(match_output_control_addr, 32'h0000_0000);
    rdchk(count_control_addr, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
